// ### hw/sfp_dev.sv
// flash end of the link: pin-state control per interface phase.
// assumes cs_n, sck, rst_n and the lines arrive asynchronously to clk_i and
// that sck half periods are well over the synchroniser delay.
//
// How it works
// RL1: single input: host drives io0, device floats
// RL2: single output: device drives io1 with data
// RL3: quad program address uses io0 only
// RL4: ddr single input: host drives io0, plus io3 as pause while quad is off
// RL5: ddr dual input: host drives io0, io1
// RL6: ddr quad input: host drives all four
// RL7: ddr single output: drive io1, float io2-3
// RL8: ddr dual output: drive io0-1, float io2-3
// RL9: ddr quad output: drive all four lines
// RL10: output drivers off outside output phases
// RL11: host toggles clock, may hold when paused
// RL12: enables switch only at decoded phase boundaries; the device also drops its enables while paused in the output phase
// RL13: io3 is pause input unless quad enabled
// RL14: ddr commands ignore pause and write guard after the instruction
// RL15: dummy count comes from latency code field
`timescale 1ns/1ps
`default_nettype none

module sfp_dev
	import sfp_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// link
	sfp_if.dev               lnk,
	// config_reg fields
	input  wire logic        quad_en_i,
	input  wire logic [1:0]  lat_code_i,
	// decoded command
	output logic      [7:0]  cmd_o,
	output logic      [23:0] addr_o,
	output logic             cmd_valid_o,
	// read data stream toward the host
	input  wire logic [7:0]  rd_data_i,
	input  wire logic        rd_valid_i,
	output logic             rd_ready_o,
	// write data received from the host
	output logic      [7:0]  wr_data_o,
	output logic             wr_valid_o,
	output var sfp_ph_t      phase_o
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: bit 6 reset pin, 5 select, 4 clock, 3:0 lines

	logic [6:0]  s1_r;
	logic [6:0]  s2_r;
	logic [6:0]  s3_r;
	logic [6:0]  lv_r;
	logic        sck_q_r;
	logic        sel_q_r;
	logic [3:0]  io_l;
	logic        sel;
	logic        rise;
	logic        fall;
	logic        pause;
	logic        go_r;
	logic        go_f;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s1_r    <= PIN_IDLE;
			s2_r    <= PIN_IDLE;
			s3_r    <= PIN_IDLE;
			lv_r    <= PIN_IDLE;
			sck_q_r <= 1'b0;
			sel_q_r <= 1'b0;
		end
		else
		begin
			s1_r    <= {lnk.rst_n, lnk.cs_n, lnk.sck, lnk.line};
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			// a level counts only once the second and third stage agree
			lv_r    <= (s2_r & s3_r) | (lv_r & (s2_r ^ s3_r));
			sck_q_r <= lv_r[4];
			sel_q_r <= sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge events

	sfp_ph_t     ph_r;
	sfp_fmt_t    fmt_r;
	logic [4:0]  bcnt_r;
	logic [3:0]  dcnt_r;
	logic [23:0] sr_r;
	logic [2:0]  wcur;
	logic [4:0]  total;
	logic [4:0]  bnx;
	logic        done;
	logic [23:0] sh;
	logic [3:0]  lat_n;
	sfp_fmt_t    nf;
	logic        a_beat;
	logic        i_beat;

	assign io_l  = lv_r[3:0];
	// reset pin low acts like a deselect
	assign sel   = lv_r[6] & ~lv_r[5];
	assign rise  = sel & lv_r[4] & ~sck_q_r;
	assign fall  = sel & ~lv_r[4] & sck_q_r;
	// pause freezes progress as if the clock stood still; in ddr only during the instruction
	assign pause = ~quad_en_i & ~io_l[3] & ~(fmt_r.ddr & (ph_r != PH_INSTR)); // see RL13 see RL14
	assign go_r  = rise & ~pause;
	assign go_f  = fall & ~pause;

	// ddr address starts on the first rise after the instruction
	assign a_beat = go_r | (go_f & fmt_r.ddr & (bcnt_r != 5'h00)); // see RL4 see RL5 see RL6
	assign i_beat = go_r | (go_f & fmt_r.ddr);
	assign lat_n  = fmt_r.lat ? lat_cycles(lat_code_i) : 4'h0; // see RL15

	always_comb
	begin
		wcur  = W1;
		total = INSTR_BITS;
		if (ph_r == PH_ADDR)
		begin
			wcur  = fmt_r.aw;
			total = ADDR_BITS;
		end
		else if (ph_r == PH_DIN)
		begin
			wcur  = fmt_r.dw;
			total = BYTE_BITS;
		end
	end

	// single inputs always sample io0, so quad program address ignores io1-3
	assign sh   = shift_in(wcur, sr_r, io_l, 1'b0); // see RL1 see RL3
	assign nf   = cmd_fmt(sh[7:0]);
	assign bnx  = bcnt_r + {2'h0, wcur};
	assign done = (bnx == total);

	////////////////////////////////////////////////////////////////////////
	// phase sequencer

	always_ff @(posedge clk_i)
	begin
		cmd_valid_o <= 1'b0;
		wr_valid_o  <= 1'b0;
		if (sys_rst_i)
		begin
			ph_r      <= PH_IDLE;
			fmt_r     <= '0;
			bcnt_r    <= '0;
			dcnt_r    <= '0;
			sr_r      <= '0;
			cmd_o     <= '0;
			addr_o    <= '0;
			wr_data_o <= '0;
		end
		else if (!sel)
		begin
			ph_r   <= PH_IDLE;
			fmt_r  <= '0;
			bcnt_r <= '0;
			dcnt_r <= '0;
		end
		else
		begin
			case (ph_r)
			PH_IDLE:
				ph_r <= PH_INSTR;
			PH_INSTR:
				if (go_r)
				begin
					sr_r   <= sh;
					bcnt_r <= done ? 5'h00 : bnx;
					if (done)
					begin
						cmd_o <= sh[7:0];
						fmt_r <= nf;
						if (nf.aw == W0)
						begin
							cmd_valid_o <= 1'b1;
							ph_r        <= PH_DONE;
						end
						else
							ph_r <= PH_ADDR; // see RL12
					end
				end
			PH_ADDR:
				if (a_beat)
				begin
					sr_r   <= sh;
					bcnt_r <= done ? 5'h00 : bnx;
					if (done)
					begin
						addr_o      <= sh;
						cmd_valid_o <= 1'b1;
						dcnt_r      <= '0;
						ph_r        <= fmt_r.wr ? PH_DIN : PH_DUMMY; // see RL12
					end
				end
			PH_DUMMY:
				if (go_f)
				begin
					// data starts on the fall that ends the last dummy cycle
					if (dcnt_r == lat_n)
						ph_r <= PH_DOUT; // see RL12 see RL15
					else
						dcnt_r <= dcnt_r + 4'h1;
				end
			PH_DIN:
				if (i_beat)
				begin
					sr_r   <= sh;
					bcnt_r <= done ? 5'h00 : bnx;
					if (done)
					begin
						wr_data_o  <= sh[7:0];
						wr_valid_o <= 1'b1;
					end
				end
			default:
				ph_r <= ph_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-entry read buffer; flushed when the command ends

	logic [7:0]  mem [2];
	logic        wp_r;
	logic        rp_r;
	logic [1:0]  cnt_r;
	logic        push;
	logic        pop;
	logic        drive;
	logic        load;
	logic [4:0]  rem_r;
	logic [7:0]  osr_r;
	logic [3:0]  dout_r;
	logic [7:0]  nb;
	logic [4:0]  wd;

	assign rd_ready_o = (cnt_r != 2'h2);
	assign push       = rd_valid_i & rd_ready_o;
	assign load       = (ph_r == PH_DUMMY) & go_f & (dcnt_r == lat_n);
	assign drive      = load | ((ph_r == PH_DOUT) & (go_f | (go_r & fmt_r.ddr)));
	assign pop        = drive & (rem_r == 5'h00) & (cnt_r != 2'h0);
	// an empty buffer shows as the fill byte rather than stalling the link
	assign nb         = (cnt_r != 2'h0) ? mem[rp_r] : FILL_BYTE;
	assign wd         = {2'h0, fmt_r.dw};

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wp_r] <= rd_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || (sel_q_r && !sel))
		begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= ~wp_r;
			if (pop)
				rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output shifter: sdr moves on falls, ddr on every edge

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || !sel)
		begin
			rem_r  <= '0;
			osr_r  <= '0;
			dout_r <= '0;
		end
		else if (drive)
		begin
			if (rem_r == 5'h00)
			begin
				dout_r <= put_bits(fmt_r.dw, nb, 1'b1); // see RL2
				osr_r  <= nb << fmt_r.dw;
				rem_r  <= BYTE_BITS - wd;
			end
			else
			begin
				dout_r <= put_bits(fmt_r.dw, osr_r, 1'b1);
				osr_r  <= osr_r << fmt_r.dw;
				rem_r  <= rem_r - wd;
			end
		end
	end

	// drivers only in the output phase, and released during a pause
	assign lnk.dev_oe = ((ph_r == PH_DOUT) && !pause) ? width_mask(fmt_r.dw, 1'b1) : 4'h0; // see RL10 see RL7 see RL8 see RL9
	assign lnk.dev_io = dout_r;
	assign phase_o    = ph_r;

endmodule

`default_nettype wire

// ### hw/sfp_pkg.sv
// constants, phase enum and command formats shared by both ends of the
// multi-i/o serial flash link. assumes one 125 mhz system clock.
`default_nettype none

package sfp_pkg;

	typedef enum logic [2:0] {PH_IDLE, PH_INSTR, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_DONE} sfp_ph_t;

	typedef struct packed {
		logic [2:0] aw;
		logic [2:0] dw;
		logic       ddr;
		logic       rd;
		logic       wr;
		logic       lat;
	} sfp_fmt_t;

	// lane widths; zero address width marks a stand-alone instruction
	localparam logic [2:0] W0 = 3'h0;
	localparam logic [2:0] W1 = 3'h1;
	localparam logic [2:0] W2 = 3'h2;
	localparam logic [2:0] W4 = 3'h4;

	localparam logic [4:0] INSTR_BITS = 5'h08;
	localparam logic [4:0] ADDR_BITS  = 5'h18;
	localparam logic [4:0] BYTE_BITS  = 5'h08;

	localparam logic [7:0] OP_READ   = 8'h03;
	localparam logic [7:0] OP_FAST   = 8'h0B;
	localparam logic [7:0] OP_DOR    = 8'h3B;
	localparam logic [7:0] OP_QOR    = 8'h6B;
	localparam logic [7:0] OP_DIOR   = 8'hBB;
	localparam logic [7:0] OP_QIOR   = 8'hEB;
	localparam logic [7:0] OP_DDR1   = 8'h0D;
	localparam logic [7:0] OP_DDR2   = 8'hBD;
	localparam logic [7:0] OP_DDR4   = 8'hED;
	localparam logic [7:0] OP_PP     = 8'h02;
	localparam logic [7:0] OP_QPP    = 8'h32;

	// dummy cycles per latency_code_field value
	localparam logic [3:0] LAT_C0 = 4'h8;
	localparam logic [3:0] LAT_C1 = 4'h4;
	localparam logic [3:0] LAT_C2 = 4'h5;
	localparam logic [3:0] LAT_C3 = 4'h6;

	// synchroniser idle: reset pin high, deselected, clock low, lines pulled up
	localparam logic [6:0] PIN_IDLE  = 7'h6F;
	localparam logic [7:0] FILL_BYTE = 8'hFF;

	localparam int CLK_PERIOD_NS = 8;
	localparam int SCK_HALF_NS   = 128;
	localparam int SCK_HALF_CYC  = SCK_HALF_NS / CLK_PERIOD_NS;

	function automatic sfp_fmt_t cmd_fmt(input logic [7:0] op);
		sfp_fmt_t f;
		f = '0;
		case (op)
		OP_READ: f = '{W1, W1, 1'b0, 1'b1, 1'b0, 1'b0};
		OP_FAST: f = '{W1, W1, 1'b0, 1'b1, 1'b0, 1'b1};
		OP_DOR:  f = '{W1, W2, 1'b0, 1'b1, 1'b0, 1'b1};
		OP_QOR:  f = '{W1, W4, 1'b0, 1'b1, 1'b0, 1'b1};
		OP_DIOR: f = '{W2, W2, 1'b0, 1'b1, 1'b0, 1'b1};
		OP_QIOR: f = '{W4, W4, 1'b0, 1'b1, 1'b0, 1'b1};
		OP_DDR1: f = '{W1, W1, 1'b1, 1'b1, 1'b0, 1'b1};
		OP_DDR2: f = '{W2, W2, 1'b1, 1'b1, 1'b0, 1'b1};
		OP_DDR4: f = '{W4, W4, 1'b1, 1'b1, 1'b0, 1'b1};
		OP_PP:   f = '{W1, W1, 1'b0, 1'b0, 1'b1, 1'b0};
		OP_QPP:  f = '{W1, W4, 1'b0, 1'b0, 1'b1, 1'b0};
		default: f = '0;
		endcase
		return f;
	endfunction

	function automatic logic [3:0] lat_cycles(input logic [1:0] code);
		case (code)
		2'h0:    return LAT_C0;
		2'h1:    return LAT_C1;
		2'h2:    return LAT_C2;
		default: return LAT_C3;
		endcase
	endfunction

	// single-width reads use io1, single-width writes io0
	function automatic logic [3:0] width_mask(input logic [2:0] w, input logic rd);
		case (w)
		W4:      return 4'hF;
		W2:      return 4'h3;
		default: return rd ? 4'h2 : 4'h1;
		endcase
	endfunction

	function automatic logic [3:0] put_bits(input logic [2:0] w, input logic [7:0] b, input logic rd);
		case (w)
		W4:      return b[7:4];
		W2:      return {2'h0, b[7:6]};
		default: return rd ? {2'h0, b[7], 1'b0} : {3'h0, b[7]};
		endcase
	endfunction

	function automatic logic [23:0] shift_in(input logic [2:0] w, input logic [23:0] v,
		input logic [3:0] io, input logic rd);
		case (w)
		W4:      return {v[19:0], io};
		W2:      return {v[21:0], io[1:0]};
		default: return {v[22:0], rd ? io[1] : io[0]};
		endcase
	endfunction

endpackage

`default_nettype wire

// ### hw/sfp_if.sv
// four shared i/o lines plus select, clock and reset pin between host and flash.
// each end gives level and enable; the line value is resolved here, pulled up.
`timescale 1ns/1ps
`default_nettype none

interface sfp_if;
	logic       cs_n;
	logic       sck;
	logic       rst_n;
	logic [3:0] host_io;
	logic [3:0] host_oe;
	logic [3:0] dev_io;
	logic [3:0] dev_oe;
	logic [3:0] line;
	logic       clash;

	// two drivers on one line show up on clash; level is then meaningless
	assign line  = (dev_oe & dev_io) | (host_oe & host_io) | ~(dev_oe | host_oe);
	assign clash = |(dev_oe & host_oe);

	modport host (output cs_n, sck, rst_n, host_io, host_oe, input line);
	modport dev (input cs_n, sck, rst_n, line, output dev_io, dev_oe);
endinterface

`default_nettype wire

// ### hw/sfp_host.sv
// controller end of the link: makes select, serial clock and reset pin, and
// drives or samples the lines per phase. assumes the far end decodes the same
// command set and sees the same dummy count as dummy_i.
`timescale 1ns/1ps
`default_nettype none

module sfp_host
	import sfp_pkg::*;
#(
	parameter int HALF = SCK_HALF_CYC
)
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// link
	sfp_if.host              lnk,
	// command request
	input  wire logic        start_i,
	input  wire logic [7:0]  cmd_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [7:0]  len_i,
	input  wire logic [3:0]  dummy_i,
	input  wire logic        quad_en_i,
	input  wire logic        pause_i,
	output logic             busy_o,
	// write data
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        wr_valid_i,
	output logic             wr_ready_o,
	// read data
	output logic      [7:0]  rd_data_o,
	output logic             rd_valid_o
);

	localparam logic [7:0] TICK = 8'(HALF - 1);
	localparam logic [7:0] MID  = 8'(HALF / 2 - 1);

	sfp_ph_t     ph_r;
	sfp_fmt_t    fmt_r;
	logic [7:0]  dv_r;
	logic        sck_r;
	logic        csn_r;
	logic        rstn_r;
	logic        adv_r;
	logic [4:0]  bcnt_r;
	logic [3:0]  dcnt_r;
	logic [3:0]  dmy_r;
	logic [7:0]  left_r;
	logic [23:0] addr_r;
	logic [23:0] osr_r;
	logic [23:0] isr_r;
	logic [3:0]  s1_r;
	logic [3:0]  s2_r;
	logic [3:0]  s3_r;
	logic [3:0]  lv_r;
	logic [3:0]  hio_r;
	logic [3:0]  hoe_r;
	logic        active;
	logic        tick;
	logic        mid;
	logic        rise;
	logic        fall;
	logic        hold_line;
	logic        ddr_io3;
	logic        need_wr;
	logic        stall;
	logic        step;
	logic        beat;
	logic [2:0]  wcur;
	logic [4:0]  total;
	logic [4:0]  bnx;
	logic        done;
	logic [23:0] rsh;
	logic [3:0]  hoe_d;

	////////////////////////////////////////////////////////////////////////
	// line synchroniser and clock divider

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s1_r <= PIN_IDLE[3:0];
			s2_r <= PIN_IDLE[3:0];
			s3_r <= PIN_IDLE[3:0];
			lv_r <= PIN_IDLE[3:0];
		end
		else
		begin
			s1_r <= lnk.line;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lv_r <= (s2_r & s3_r) | (lv_r & (s2_r ^ s3_r));
		end
	end

	assign active    = (ph_r != PH_IDLE);
	assign tick      = active & (dv_r == TICK);
	assign mid       = active & (dv_r == MID);
	assign rise      = tick & ~sck_r;
	assign fall      = tick & sck_r;
	assign hold_line = active & ~quad_en_i & ~(fmt_r.ddr & (ph_r != PH_INSTR));
	// ddr address still shows pause on io3; the far end must ignore it there
	assign ddr_io3   = active & ~quad_en_i & fmt_r.ddr & (ph_r == PH_ADDR);
	assign wcur      = (ph_r == PH_ADDR) ? fmt_r.aw : ((ph_r == PH_INSTR) ? W1 : fmt_r.dw);
	assign total     = (ph_r == PH_ADDR) ? ADDR_BITS : ((ph_r == PH_INSTR) ? INSTR_BITS : BYTE_BITS);
	assign bnx       = bcnt_r + {2'h0, wcur};
	assign done      = (bnx == total);
	assign need_wr   = done & (((ph_r == PH_ADDR) & fmt_r.wr & (left_r != 8'h00))
		| ((ph_r == PH_DIN) & (left_r != 8'h01)));
	assign wr_ready_o = mid & adv_r & need_wr;
	// a missing write byte or a pause holds the clock at a steady level
	assign stall     = (pause_i & hold_line) | (wr_ready_o & ~wr_valid_i); // see RL11
	assign step      = mid & adv_r & ~stall;
	assign beat      = rise | (fall & fmt_r.ddr & (ph_r != PH_INSTR)
		& ((ph_r != PH_ADDR) | (bcnt_r != 5'h00)));
	assign rsh       = shift_in(fmt_r.dw, isr_r, lv_r, 1'b1);
	assign busy_o    = active;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || !active)
		begin
			dv_r  <= '0;
			sck_r <= 1'b0;
		end
		else if (!stall)
		begin
			dv_r <= tick ? 8'h00 : dv_r + 8'h01;
			// clock toggles through every phase; it parks low before select rises
			if (tick && !(ph_r == PH_DONE && !sck_r))
				sck_r <= ~sck_r; // see RL11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// phase sequencer

	always_ff @(posedge clk_i)
	begin
		rd_valid_o <= 1'b0;
		if (sys_rst_i)
		begin
			ph_r      <= PH_IDLE;
			fmt_r     <= '0;
			csn_r     <= 1'b1;
			rstn_r    <= 1'b0;
			adv_r     <= 1'b0;
			bcnt_r    <= '0;
			dcnt_r    <= '0;
			dmy_r     <= '0;
			left_r    <= '0;
			addr_r    <= '0;
			osr_r     <= '0;
			isr_r     <= '0;
			rd_data_o <= '0;
		end
		else
		begin
			rstn_r <= 1'b1;
			if (tick && !stall && (ph_r == PH_INSTR || ph_r == PH_ADDR || ph_r == PH_DIN))
				adv_r <= beat;
			else if (step)
				adv_r <= 1'b0;
			case (ph_r)
			PH_IDLE:
				if (start_i)
				begin
					fmt_r  <= cmd_fmt(cmd_i);
					osr_r  <= {cmd_i, 16'h0000};
					addr_r <= addr_i;
					left_r <= len_i;
					dmy_r  <= dummy_i;
					bcnt_r <= '0;
					csn_r  <= 1'b0;
					ph_r   <= PH_INSTR;
				end
			PH_INSTR, PH_ADDR, PH_DIN:
				if (step)
				begin
					bcnt_r <= done ? 5'h00 : bnx;
					osr_r  <= osr_r << wcur;
					if (done && ph_r == PH_INSTR)
					begin
						osr_r <= addr_r;
						ph_r  <= (fmt_r.aw == W0) ? PH_DONE : PH_ADDR;
					end
					else if (done && need_wr)
					begin
						osr_r <= {wr_data_i, 16'h0000};
						ph_r  <= PH_DIN;
						if (ph_r == PH_DIN)
							left_r <= left_r - 8'h01;
					end
					else if (done)
					begin
						dcnt_r <= '0;
						left_r <= (ph_r == PH_DIN) ? left_r - 8'h01 : left_r;
						ph_r   <= (ph_r == PH_ADDR && fmt_r.rd) ? PH_DUMMY : PH_DONE;
					end
				end
			PH_DUMMY:
				if (fall)
				begin
					if (dcnt_r == (fmt_r.lat ? dmy_r : 4'h0))
						ph_r <= (left_r == 8'h00) ? PH_DONE : PH_DOUT;
					else
						dcnt_r <= dcnt_r + 4'h1;
				end
			PH_DOUT:
				if (beat)
				begin
					isr_r  <= rsh;
					bcnt_r <= done ? 5'h00 : bnx;
					if (done)
					begin
						rd_data_o  <= rsh[7:0];
						rd_valid_o <= 1'b1;
						left_r     <= left_r - 8'h01;
						if (left_r == 8'h01)
							ph_r <= PH_DONE;
					end
				end
			default:
				if (tick && !sck_r)
				begin
					csn_r <= 1'b1;
					ph_r  <= PH_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// line drivers; released through dummy and read phases to avoid contention, except io3 kept as pause in sdr commands while quad is off

	always_comb
	begin
		hoe_d = 4'h0;
		if (ph_r == PH_INSTR)
			hoe_d = 4'h1;
		else if (ph_r == PH_ADDR)
			hoe_d = width_mask(fmt_r.aw, 1'b0); // see RL3 see RL4 see RL5 see RL6
		else if (ph_r == PH_DIN)
			hoe_d = width_mask(fmt_r.dw, 1'b0); // see RL1
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			hio_r <= '0;
			hoe_r <= '0;
		end
		else
		begin
			// io3 doubles as pause, io2 as write guard held inactive
			hoe_r <= hoe_d | {hold_line | ddr_io3, hold_line & (ph_r == PH_INSTR), 2'h0}; // see RL13 see RL14
			hio_r <= (put_bits(wcur, osr_r[23:16], 1'b0) & hoe_d) | ({~pause_i, 3'h4} & ~hoe_d);
		end
	end

	assign lnk.cs_n    = csn_r;
	assign lnk.sck     = sck_r;
	assign lnk.rst_n   = rstn_r;
	assign lnk.host_io = hio_r;
	assign lnk.host_oe = hoe_r;

endmodule

`default_nettype wire

// ### verification/sfp_chk.sv
// line checks between host and flash ends, interface signals as inputs
// assumes select and serial clock are sampled on the system clock
`timescale 1ns/1ps
`default_nettype none

module sfp_chk
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// link
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic [3:0] host_oe,
	input  wire logic [3:0] dev_io,
	input  wire logic [3:0] dev_oe,
	input  wire logic       clash
);
	logic       sck_r;
	logic [5:0] rise_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i)
	begin
		sck_r <= sys_rst_i ? 1'b0 : sck;
	end

	// clock rises since select fell; saturates
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || cs_n)
			rise_r <= 6'h00;
		else if (sck && !sck_r && rise_r != 6'h3F)
			rise_r <= rise_r + 6'h01;
	end

	////////////////////////////////////////////////////////////////
	chk_no_clash: assert property (!clash)
		else $error("line driven by both ends");
	chk_sel_float: assert property (cs_n [*8] |-> dev_oe == 4'h0)
		else $error("device drives while deselected");
	chk_oe_shape: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("device enable pattern illegal");
	chk_oe_on_low: assert property ($rose(dev_oe != 4'h0) |-> !sck)
		else $error("device output turned on with clock high");
	chk_instr_float: assert property (!cs_n && rise_r < 6'h0E |-> dev_oe == 4'h0)
		else $error("device drives during instruction or address");
	chk_host_instr: assert property (!cs_n && !$past(cs_n, 2) && rise_r < 6'h08 |-> host_oe[1:0] == 2'h1)
		else $error("host instruction lanes wrong");
	chk_out_host_off: assert property (dev_oe != 4'h0 |-> host_oe[1:0] == 2'h0)
		else $error("host drives data lanes during output");
	chk_dev_steady: assert property ($rose(sck) |-> $stable(dev_io) [*2])
		else $error("device data moved at sampling edge");
endmodule

`default_nettype wire

// ### verification/testbench.sv
// bench: both link ends joined, stimulated and checked from user sides
// assumes package, interface and both ends compile first
`timescale 1ns/1ps
`default_nettype none

module testbench
	import sfp_pkg::*;
();
	localparam int LIMIT = 90000;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        start = 1'b0;
	logic        pause = 1'b0;
	logic        quad_en = 1'b0;
	logic        wr_valid = 1'b0;
	logic        rd_valid = 1'b0;
	logic        wr_acc;
	logic [1:0]  lat = 2'h0;
	logic [3:0]  dummy = 4'h0;
	logic [7:0]  cmd = 8'h00;
	logic [7:0]  len = 8'h00;
	logic [7:0]  wr_data = 8'h00;
	logic [7:0]  rd_data = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic [7:0]  cmd_o, wr_data_o, rd_data_o;
	logic [23:0] addr_o;
	logic        cmd_valid, rd_ready, wr_valid_o, busy, wr_ready, rd_valid_o;
	sfp_ph_t     phase;
	logic [31:0] q_cmd[$];
	logic [31:0] exp_c;
	logic [7:0]  exp_p;
	logic [7:0]  q_rd[$], q_wr[$];
	int          n_errors = 0, checks_done = 0, cyc = 0, n_rx = 0;
	logic [3:0]  lat_tab [4] = '{LAT_C0, LAT_C1, LAT_C2, LAT_C3};
	logic [7:0]  ops [11] = '{OP_READ, OP_FAST, OP_DOR, OP_QOR, OP_DIOR, OP_QIOR,
		OP_DDR1, OP_DDR2, OP_DDR4, OP_PP, OP_QPP};

	sfp_if i_sfp_if ();
	sfp_dev i_sfp_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(i_sfp_if), .quad_en_i(quad_en),
		.lat_code_i(lat), .cmd_o(cmd_o), .addr_o(addr_o), .cmd_valid_o(cmd_valid), .rd_data_i(rd_data),
		.rd_valid_i(rd_valid), .rd_ready_o(rd_ready), .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o),
		.phase_o(phase));
	sfp_host #(.HALF(12)) i_sfp_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(i_sfp_if),
		.start_i(start), .cmd_i(cmd), .addr_i(addr), .len_i(len), .dummy_i(dummy), .quad_en_i(quad_en),
		.pause_i(pause), .busy_o(busy), .wr_data_i(wr_data), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
	sfp_chk i_sfp_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n(i_sfp_if.cs_n), .sck(i_sfp_if.sck),
		.host_oe(i_sfp_if.host_oe), .dev_io(i_sfp_if.dev_io), .dev_oe(i_sfp_if.dev_oe),
		.clash(i_sfp_if.clash));

	initial
	begin
		forever #4 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic cmp_cmd(input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD cmd_addr exp %h got %h", e, s);
		end
	endtask

	task automatic run(input logic [7:0] op);
		int   w;
		logic q;
		q = op inside {OP_QOR, OP_QIOR, OP_DDR4, OP_QPP};
		@(posedge clk_i);
		#1;
		cmd = op;
		addr = 24'($urandom);
		lat = 2'($urandom);
		dummy = lat_tab[lat];
		quad_en = q ? 1'b1 : (op == OP_PP || op == OP_DDR1) ? 1'b0 : 1'($urandom);
		len = (op == OP_PP || op == OP_QPP) ? 8'($urandom_range(3)) : 8'($urandom_range(4, 1));
		q_rd.delete();
		n_rx = 0;
		q_cmd.push_back({op, addr});
		start = 1'b1;
		@(posedge clk_i);
		#1;
		start = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		// second request while busy must be dropped
		start = 1'b1;
		cmd = OP_PP;
		@(posedge clk_i);
		#1;
		start = 1'b0;
		if (!quad_en && (op == OP_PP || op == OP_DDR1))
		begin
			repeat (400) @(posedge clk_i);
			#1;
			pause = 1'b1;
			repeat (40) @(posedge clk_i);
			#1;
			pause = 1'b0;
		end
		w = 0;
		while (busy !== 1'b0 && w < 6000)
		begin
			@(posedge clk_i);
			w++;
		end
		repeat (16) @(posedge clk_i);
		// a command that never ends counts as a mismatch
		if (busy !== 1'b0)
			n_errors++;
		cmp_byte("count", len, n_rx[7:0]);
	endtask

	////////////////////////////////////////////////////////////////
	// read source raises valid only with ready seen, so no byte waits across commands
	always @(posedge clk_i)
	begin
		if (rd_valid && rd_ready)
			q_rd.push_back(rd_data);
		#1;
		rd_valid = !i_sfp_if.cs_n && rd_ready && ($urandom_range(1) == 1);
		rd_data = 8'($urandom);
	end

	always @(posedge clk_i)
	begin
		wr_acc = wr_valid && wr_ready;
		if (wr_acc)
			q_wr.push_back(wr_data);
		#1;
		if (wr_acc || !wr_valid)
		begin
			wr_valid = $urandom_range(3) != 0;
			wr_data = 8'($urandom);
		end
	end

	always @(posedge clk_i)
	begin
		if (cmd_valid === 1'b1)
		begin
			exp_c = q_cmd.size() ? q_cmd.pop_front() : 32'hX;
			cmp_cmd(exp_c, {cmd_o, addr_o});
			// writes go straight to data input, reads to the latency phase
			exp_p = (exp_c[31:24] inside {OP_PP, OP_QPP}) ? 8'(PH_DIN) : 8'(PH_DUMMY);
			cmp_byte("phase", exp_p, 8'(phase));
		end
		if (rd_valid_o === 1'b1)
		begin
			n_rx++;
			cmp_byte("rd", q_rd.size() ? q_rd.pop_front() : 8'hX, rd_data_o);
		end
		if (wr_valid_o === 1'b1)
		begin
			n_rx++;
			cmp_byte("wr", q_wr.size() ? q_wr.pop_front() : 8'hX, wr_data_o);
		end
	end

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			n_errors++;
			print_verdict();
		end
	end

	initial
	begin
		void'($urandom(32'h487B084B));
		repeat (2) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		@(posedge clk_i);
		for (int r = 0; r < 2; r++)
			foreach (ops[i])
				run(ops[i]);
		print_verdict();
	end
endmodule

`default_nettype wire
